//--- shared/hub_strap_pkg.sv
// Constants and types shared by the strap sampling and status block
package hub_strap_pkg;

    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;

    // Register byte addresses
    localparam logic [7:0] STRAP_STATUS_OFS = 8'h00;
    localparam logic [7:0] SLAVE_ADDR_OFS   = 8'h04;
    localparam logic [7:0] PORT_CTRL_OFS    = 8'h08;

    // Strap status field positions
    localparam int ST_POWER_MGMT_BIT = 0;
    localparam int ST_GANGED_BIT     = 1;
    localparam int ST_PORT_IND_BIT   = 2;
    localparam int ST_MGMT_MODE_BIT  = 3;
    localparam int ST_USB3_BIT       = 4;
    localparam int ST_CAPTURED_BIT   = 5;

    // Port control field positions
    localparam int PC_POWER_BIT      = 0;

    // Fixed upper bits of the management-bus slave address
    localparam logic [3:0] SLAVE_ADDR_HIGH = 4'h8;

    // Strap level held during reset (pins are pulled up) and port control reset value
    localparam logic STRAP_RESET_LEVEL = 1'b1;
    localparam logic PORT_CTRL_RESET   = 1'b0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic port_indicator;
        logic ganged;
        logic power_mgmt;
        logic mgmt_mode_n;
    } straps_t;

    // Seven-bit slave address: 1000 p g m (port indicator, ganged, power management straps)
    function automatic logic [6:0] slave_address(input straps_t s);
        slave_address = {SLAVE_ADDR_HIGH, s.port_indicator, s.ganged, s.power_mgmt};
    endfunction

endpackage

//--- design/strap_capture.sv
// One-shot capture of the strap pins at the release of reset
`timescale 1ns/100ps
module strap_capture
    import hub_strap_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Strap pins
    input  wire hub_strap_pkg::straps_t pins_i,
    // Held values
    output hub_strap_pkg::straps_t straps_o,
    output logic                   captured_o
);
    import hub_strap_pkg::*;

    straps_t next_straps;
    logic    next_captured;

    // First edge after release samples the pins, then nothing changes
    always_comb
    begin
        next_straps   = straps_o;
        next_captured = captured_o;
        if (rst_i)
        begin
            next_straps   = '{default: STRAP_RESET_LEVEL};
            next_captured = 1'b0;
        end
        else if (!captured_o)
        begin
            next_straps   = pins_i;
            next_captured = 1'b1;
        end
        // Later pin changes are ignored
    end

    always_ff @(posedge clk_i)
    begin
        straps_o   <= next_straps;
        captured_o <= next_captured;
    end

endmodule // strap_capture

//--- design/hub_strap_sampling_status.sv
// Strap sampling, status pins and AXI4-Lite register slave of the hub
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module hub_strap_sampling_status
(
    // Clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    // Strap pins
    input  wire logic                              power_mgmt_strap_addr1_i,
    input  wire logic                              ganged_strap_addr2_i,
    input  wire logic                              port_indicator_strap_addr3_i,
    input  wire logic                              mgmt_bus_mode_select_n_i,
    // Hub core status
    input  wire logic                              usb3_mode_i,
    // Status and control outputs
    output logic                                   upstream_usb3_o,
    output logic                                   port_power_enable_out_o,
    output logic                                   power_led_enable_o,
    output logic                                   port_led_enable_o,
    output logic                                   mgmt_bus_enable_o,
    output logic [6:0]                             mgmt_slave_addr_o,
    // AXI4-Lite write address
    input  wire logic                              s_axi_awvalid_i,
    output logic                                   s_axi_awready_o,
    input  wire logic [hub_strap_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic [2:0]                        s_axi_awprot_i,
    // AXI4-Lite write data
    input  wire logic                              s_axi_wvalid_i,
    output logic                                   s_axi_wready_o,
    input  wire logic [hub_strap_pkg::AXI_DATA_W-1:0] s_axi_wdata_i,
    input  wire logic [3:0]                        s_axi_wstrb_i,
    // AXI4-Lite write response
    output logic                                   s_axi_bvalid_o,
    input  wire logic                              s_axi_bready_i,
    output logic [1:0]                             s_axi_bresp_o,
    // AXI4-Lite read address
    input  wire logic                              s_axi_arvalid_i,
    output logic                                   s_axi_arready_o,
    input  wire logic [hub_strap_pkg::AXI_ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic [2:0]                        s_axi_arprot_i,
    // AXI4-Lite read data
    output logic                                   s_axi_rvalid_o,
    input  wire logic                              s_axi_rready_i,
    output logic [hub_strap_pkg::AXI_DATA_W-1:0]   s_axi_rdata_o,
    output logic [1:0]                             s_axi_rresp_o
);
    import hub_strap_pkg::*;

    straps_t pins;
    straps_t straps;
    logic    captured;

    assign pins.port_indicator = port_indicator_strap_addr3_i;
    assign pins.ganged         = ganged_strap_addr2_i;
    assign pins.power_mgmt     = power_mgmt_strap_addr1_i;
    assign pins.mgmt_mode_n    = mgmt_bus_mode_select_n_i;

    // Pins are assumed steady across reset release
    strap_capture u_capture
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .pins_i     (pins),
        .straps_o   (straps),
        .captured_o (captured)
    );

    // Status outputs
    logic       port_power_req;
    logic       next_usb3;
    logic       next_port_power;
    logic       next_power_led;
    logic       next_port_led;
    logic       next_mgmt_en;
    logic [6:0] next_slave_addr;
    logic       full_pm;
    logic       mgmt_mode;

    assign full_pm   = captured && !straps.power_mgmt;
    assign mgmt_mode = captured && !straps.mgmt_mode_n;

    always_comb
    begin
        next_usb3       = usb3_mode_i;
        // Ports stay unpowered until the straps are known, then follow the mode
        next_port_power = captured && (full_pm ? port_power_req : 1'b1);
        next_power_led  = captured && !straps.ganged;
        next_port_led   = captured && !straps.port_indicator;
        next_mgmt_en    = mgmt_mode;
        next_slave_addr = 7'h00;
        if (mgmt_mode)
        begin
            next_slave_addr = slave_address(straps);
        end
        if (rst_i)
        begin
            next_usb3       = 1'b0;
            next_port_power = 1'b0;
            next_power_led  = 1'b0;
            next_port_led   = 1'b0;
            next_mgmt_en    = 1'b0;
            next_slave_addr = 7'h00;
        end
    end

    always_ff @(posedge clk_i)
    begin
        upstream_usb3_o         <= next_usb3;
        port_power_enable_out_o <= next_port_power;
        power_led_enable_o      <= next_power_led;
        port_led_enable_o       <= next_port_led;
        mgmt_bus_enable_o       <= next_mgmt_en;
        mgmt_slave_addr_o       <= next_slave_addr;
    end

    // AXI4-Lite write path
    logic                  aw_held;
    logic                  w_held;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic [AXI_DATA_W-1:0] w_data;
    logic [3:0]            w_strb;
    logic                  next_aw_held;
    logic                  next_w_held;
    logic [AXI_ADDR_W-1:0] next_aw_addr;
    logic [AXI_DATA_W-1:0] next_w_data;
    logic [3:0]            next_w_strb;
    logic                  next_awready;
    logic                  next_wready;
    logic                  next_bvalid;
    logic [1:0]            next_bresp;
    logic                  next_port_power_req;

    always_comb
    begin
        next_aw_held        = aw_held;
        next_w_held         = w_held;
        next_aw_addr        = aw_addr;
        next_w_data         = w_data;
        next_w_strb         = w_strb;
        next_bvalid         = s_axi_bvalid_o;
        next_bresp          = s_axi_bresp_o;
        next_port_power_req = port_power_req;
        if (s_axi_awvalid_i && s_axi_awready_o)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata_i;
            next_w_strb = s_axi_wstrb_i;
        end
        if (aw_held && w_held && !s_axi_bvalid_o)
        begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            case (aw_addr[AXI_ADDR_W-1:2])
                PORT_CTRL_OFS[AXI_ADDR_W-1:2]:
                begin
                    if (w_strb[0])
                    begin
                        next_port_power_req = w_data[PC_POWER_BIT];
                    end
                end
                STRAP_STATUS_OFS[AXI_ADDR_W-1:2],
                SLAVE_ADDR_OFS[AXI_ADDR_W-1:2]:
                begin
                    next_bresp = RESP_OKAY;
                end
                default:
                begin
                    next_bresp = RESP_SLVERR;
                end
            endcase
        end
        if (s_axi_bvalid_o && s_axi_bready_i)
        begin
            next_bvalid = 1'b0;
        end
        // Take a new item only when its holding slot is free
        next_awready = !next_aw_held && !(s_axi_awvalid_i && s_axi_awready_o);
        next_wready  = !next_w_held && !(s_axi_wvalid_i && s_axi_wready_o);
        if (rst_i)
        begin
            next_aw_held        = 1'b0;
            next_w_held         = 1'b0;
            next_aw_addr        = '0;
            next_w_data         = '0;
            next_w_strb         = 4'h0;
            next_bvalid         = 1'b0;
            next_bresp          = RESP_OKAY;
            next_awready        = 1'b0;
            next_wready         = 1'b0;
            next_port_power_req = PORT_CTRL_RESET;
        end
    end

    always_ff @(posedge clk_i)
    begin
        aw_held         <= next_aw_held;
        w_held          <= next_w_held;
        aw_addr         <= next_aw_addr;
        w_data          <= next_w_data;
        w_strb          <= next_w_strb;
        s_axi_awready_o <= next_awready;
        s_axi_wready_o  <= next_wready;
        s_axi_bvalid_o  <= next_bvalid;
        s_axi_bresp_o   <= next_bresp;
        port_power_req  <= next_port_power_req;
    end

    // AXI4-Lite read path
    logic [AXI_DATA_W-1:0] next_rdata;
    logic [1:0]            next_rresp;
    logic                  next_rvalid;
    logic                  next_arready;
    logic [AXI_DATA_W-1:0] status_word;

    always_comb
    begin
        status_word                    = '0;
        status_word[ST_POWER_MGMT_BIT] = straps.power_mgmt;
        status_word[ST_GANGED_BIT]     = straps.ganged;
        status_word[ST_PORT_IND_BIT]   = straps.port_indicator;
        status_word[ST_MGMT_MODE_BIT]  = straps.mgmt_mode_n;
        status_word[ST_USB3_BIT]       = upstream_usb3_o;
        status_word[ST_CAPTURED_BIT]   = captured;
    end

    always_comb
    begin
        next_rdata   = s_axi_rdata_o;
        next_rresp   = s_axi_rresp_o;
        next_rvalid  = s_axi_rvalid_o;
        next_arready = s_axi_arready_o;
        if (s_axi_rvalid_o && s_axi_rready_i)
        begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
        if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rresp   = RESP_OKAY;
            next_rdata   = '0;
            case (s_axi_araddr_i[AXI_ADDR_W-1:2])
                STRAP_STATUS_OFS[AXI_ADDR_W-1:2]:
                begin
                    next_rdata = status_word;
                end
                SLAVE_ADDR_OFS[AXI_ADDR_W-1:2]:
                begin
                    next_rdata[6:0] = slave_address(straps);
                end
                PORT_CTRL_OFS[AXI_ADDR_W-1:2]:
                begin
                    next_rdata[PC_POWER_BIT] = port_power_req;
                end
                default:
                begin
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
        if (rst_i)
        begin
            next_rdata   = '0;
            next_rresp   = RESP_OKAY;
            next_rvalid  = 1'b0;
            next_arready = 1'b0;
        end
        else if (!s_axi_rvalid_o && !s_axi_arready_o && !(s_axi_arvalid_i && s_axi_arready_o))
        begin
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        s_axi_rdata_o   <= next_rdata;
        s_axi_rresp_o   <= next_rresp;
        s_axi_rvalid_o  <= next_rvalid;
        s_axi_arready_o <= next_arready;
    end

endmodule // hub_strap_sampling_status

//--- sim/strap_board_model.sv
// Board model: strap resistors seen by the hub pins
`timescale 1ns/100ps
module strap_board_model
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Bench controls
    input  wire logic [3:0] level_i,
    input  wire logic       wiggle_i,
    // Strap pins
    output logic [3:0]      pins_o
);
    logic [3:0] held;
    logic [3:0] next_held;

    always_comb
    begin
        next_held = held;
        if (rst_i)
            next_held = level_i;
        else if (wiggle_i)
            next_held = ~held;
    end

    always_ff @(posedge clk_i)
    begin
        held <= next_held;
    end

    // Level is steady across the release edge, then may move freely
    assign pins_o = rst_i ? level_i : held;
endmodule // strap_board_model

//--- sim/hub_strap_sampling_status_chk.sv
// Assertions on the strap sampling and status block ports
`timescale 1ns/100ps
module hub_strap_sampling_status_chk
(
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // Straps and status
    input wire logic       power_mgmt_strap_addr1_i,
    input wire logic       ganged_strap_addr2_i,
    input wire logic       port_indicator_strap_addr3_i,
    input wire logic       mgmt_bus_mode_select_n_i,
    input wire logic       usb3_mode_i,
    input wire logic       upstream_usb3_o,
    input wire logic       port_power_enable_out_o,
    input wire logic       power_led_enable_o,
    input wire logic       port_led_enable_o,
    input wire logic       mgmt_bus_enable_o,
    input wire logic [6:0] mgmt_slave_addr_o,
    // Read channels
    input wire logic       s_axi_arvalid_i,
    input wire logic       s_axi_arready_o,
    input wire logic       s_axi_rvalid_o,
    input wire logic       s_axi_rready_i
);
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    logic [3:0] ref_s;
    logic [3:0] next_ref_s;
    logic       ready;

    // Copy of the pins at the first edge after reset release
    always_comb
    begin
        next_cnt = (cnt == 2'h3) ? cnt : cnt + 2'h1;
        next_ref_s = ref_s;
        if (cnt == 2'h0)
            next_ref_s = {mgmt_bus_mode_select_n_i, port_indicator_strap_addr3_i,
                          ganged_strap_addr2_i, power_mgmt_strap_addr1_i};
        if (rst_i)
            next_cnt = 2'h0;
    end

    always_ff @(posedge clk_i)
    begin
        cnt   <= next_cnt;
        ref_s <= next_ref_s;
    end

    assign ready = (cnt == 2'h3);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_usb3_follow: assert property (
        !$past(rst_i) |-> upstream_usb3_o == $past(usb3_mode_i))
        else $error("upstream speed status does not follow core mode");
    a_power_led: assert property (
        ready |-> power_led_enable_o == !ref_s[1])
        else $error("power led enable wrong for ganged strap");
    a_port_led: assert property (
        ready |-> port_led_enable_o == !ref_s[2])
        else $error("port led enable wrong for indicator strap");
    a_bus_enable: assert property (
        ready |-> mgmt_bus_enable_o == !ref_s[3])
        else $error("management bus enable wrong for mode strap");
    a_slave_addr: assert property (
        ready |-> mgmt_slave_addr_o == (ref_s[3] ? 7'h0 : {4'h8, ref_s[2:0]}))
        else $error("slave address wrong for captured straps");
    a_power_no_pm: assert property (
        ready && ref_s[0] |-> port_power_enable_out_o)
        else $error("port power not held on without full power management");
    a_straps_held: assert property (
        ready |=> $stable(mgmt_slave_addr_o) && $stable(power_led_enable_o)
                  && $stable(port_led_enable_o))
        else $error("strap derived output moved after capture");
    a_read_answer: assert property (
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read data not offered after address taken");
    a_read_once: assert property (
        s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
        else $error("read data offered twice for one request");
endmodule // hub_strap_sampling_status_chk

bind hub_strap_sampling_status hub_strap_sampling_status_chk u_chk
(
    .clk_i, .rst_i, .power_mgmt_strap_addr1_i, .ganged_strap_addr2_i,
    .port_indicator_strap_addr3_i, .mgmt_bus_mode_select_n_i, .usb3_mode_i,
    .upstream_usb3_o, .port_power_enable_out_o, .power_led_enable_o,
    .port_led_enable_o, .mgmt_bus_enable_o, .mgmt_slave_addr_o,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i
);

//--- sim/hub_strap_sampling_status_tb_top.sv
// Self-checking bench for the strap sampling and status block
`timescale 1ns/100ps
module hub_strap_sampling_status_tb_top;
    import hub_strap_pkg::*;
    logic        clk_i, rst_i, usb3, wig, awv, wv, arv;
    logic        up, pwr, pled, tled, mben, awr, wr, bv, arr, rv;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd;
    logic [3:0]  lvl, pins;
    logic [6:0]  sadr;
    logic [1:0]  br, rr;
    int          errors, n_compared;
    logic [3:0]  pats [5] = '{4'h0, 4'hf, 4'h5, 4'ha, 4'h6};

    strap_board_model board
    (
        .clk_i(clk_i), .rst_i(rst_i), .level_i(lvl), .wiggle_i(wig), .pins_o(pins)
    );

    hub_strap_sampling_status uut
    (
        .clk_i(clk_i), .rst_i(rst_i),
        .power_mgmt_strap_addr1_i(pins[0]), .ganged_strap_addr2_i(pins[1]),
        .port_indicator_strap_addr3_i(pins[2]), .mgmt_bus_mode_select_n_i(pins[3]),
        .usb3_mode_i(usb3), .upstream_usb3_o(up), .port_power_enable_out_o(pwr),
        .power_led_enable_o(pled), .port_led_enable_o(tled), .mgmt_bus_enable_o(mben),
        .mgmt_slave_addr_o(sadr),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
        .s_axi_awprot_i(3'h0), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(1'b1), .s_axi_bresp_o(br), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        int n;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk_i);
            if (awv && awr)
                awv <= 1'b0;
            if (wv && wr)
                wv <= 1'b0;
            if (bv)
                break;
        end
        rs = br;
        if (n == 50)
        begin
            errors++;
            $display("MISMATCH t=%0t write response never came", $time);
        end
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        int n;
        ara <= a;
        arv <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk_i);
            if (arv && arr)
                arv <= 1'b0;
            if (rv)
                break;
        end
        d = rd;
        rs = rr;
        if (n == 50)
        begin
            errors++;
            $display("MISMATCH t=%0t read data never came", $time);
        end
    endtask

    initial
    begin
        logic [3:0]  p;
        logic [31:0] d;
        logic [1:0]  rs;
        errors = 0;
        n_compared = 0;
        rst_i = 1'b1;
        lvl = 4'hf;
        {usb3, wig, awv, wv, arv} = 5'h0;
        {awa, ara, wd} = 48'h0;
        @(posedge clk_i);
        foreach (pats[i])
        begin
            p = pats[i];
            lvl <= p;
            rst_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            rst_i <= 1'b0;
            usb3 <= p[1];
            repeat (4) @(posedge clk_i);
            check(32'(up), 32'(p[1]));
            check(32'(pled), 32'(!p[1]));
            check(32'(tled), 32'(!p[2]));
            check(32'(mben), 32'(!p[3]));
            check(32'(sadr), p[3] ? 32'h0 : 32'({4'h8, p[2:0]}));
            check(32'(pwr), 32'(p[0]));
            axi_write(PORT_CTRL_OFS, 32'h1, rs);
            check(32'(rs), 32'(RESP_OKAY));
            repeat (2) @(posedge clk_i);
            check(32'(pwr), 32'h1);
            axi_read(PORT_CTRL_OFS, d, rs);
            check(d, 32'h1);
            axi_write(PORT_CTRL_OFS, 32'h0, rs);
            repeat (2) @(posedge clk_i);
            check(32'(pwr), 32'(p[0]));
            wig <= 1'b1;
            repeat (6) @(posedge clk_i);
            wig <= 1'b0;
            axi_write(STRAP_STATUS_OFS, 32'hff, rs);
            check(32'(rs), 32'(RESP_OKAY));
            axi_read(STRAP_STATUS_OFS, d, rs);
            check(d, {26'h0, 1'b1, p[1], p});
            axi_read(SLAVE_ADDR_OFS, d, rs);
            check(d, {25'h0, 4'h8, p[2:0]});
            check(32'(sadr), p[3] ? 32'h0 : 32'({4'h8, p[2:0]}));
            // Speed status tracks the core after the straps are settled
            usb3 <= !p[1];
            repeat (2) @(posedge clk_i);
            check(32'(up), 32'(!p[1]));
        end
        // Unmapped places answer with an error and change nothing
        axi_read(8'h0c, d, rs);
        check(32'(rs), 32'(RESP_SLVERR));
        axi_write(8'h10, 32'h1, rs);
        check(32'(rs), 32'(RESP_SLVERR));
        repeat (2) @(posedge clk_i);
        check(32'(pwr), 32'h0);
        complete_run();
    end

    initial
    begin
        repeat (5000) @(posedge clk_i);
        errors++;
        $display("MISMATCH t=%0t run did not finish in time", $time);
        complete_run();
    end
endmodule // hub_strap_sampling_status_tb_top
